// File: design/lineif_receive_output_port.sv
// Register access over APB and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module lineif_receive_output_port (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic irq,
	input wire logic [lineif_rx_pkg::CHANNELS-1:0] rxRecoveredClkIn,
	input wire logic [lineif_rx_pkg::CHANNELS-1:0] rx_line_positive_input,
	input wire logic [lineif_rx_pkg::CHANNELS-1:0] rx_line_negative_input,
	input wire logic rx_output_silence_on_loss,
	output logic [lineif_rx_pkg::CHANNELS-1:0] rxRecoveredClkOut,
	output logic [lineif_rx_pkg::CHANNELS-1:0] rx_positive_rail_data,
	output logic [lineif_rx_pkg::CHANNELS-1:0] rx_negative_rail_data,
	output logic [lineif_rx_pkg::CHANNELS-1:0] rx_signal_lost_flag
);
	import lineif_rx_pkg::*;

	// Whole state of the port: registers, per channel decoder and bus read data.
	typedef struct packed {
		logic [3:0] singleRail;
		logic [3:0] amiMode;
		logic [7:0] intStatus;
		logic [7:0] intMask;
		logic [31:0] readData;
		logic muteMeta;
		logic muteSync;
		logic [3:0] clkOut;
		logic [3:0] posOut;
		logic [3:0] negOut;
		logic [3:0] lost;
		logic [3:0] lastPositive;
		logic [3:0] seenPulse;
		logic [3:0][7:0] zeroCount;
		logic [3:0][6:0] stallCount;
	} port_t;

	port_t state;
	port_t next_state;

	logic [3:0] clkLevel;
	logic [3:0] clkRise;
	logic [3:0] linePos;
	logic [3:0] lineNeg;
	logic [3:0] pulseNow;
	logic [3:0] violationNow;
	logic [3:0] stallNow;
	logic [3:0] lostNext;
	logic [3:0] muteNow;
	logic setupRead;
	logic accessWrite;
	// Decoded register select of the current bus address.
	logic [4:0] regHit;

	// Decodes a byte address into a register select, bit 4 marks a hit.
	function automatic logic [4:0] regSelect(input logic [11:0] addr);
		case (addr)
			OFFS_CONTROL: regSelect = 5'h11;
			OFFS_LOSS_STATE: regSelect = 5'h12;
			OFFS_INT_STATUS: regSelect = 5'h14;
			OFFS_INT_MASK: regSelect = 5'h18;
			default: regSelect = 5'h00;
		endcase
	endfunction

	// One synchroniser and edge finder per channel.
	genvar g;
	generate
		for (g = 0; g < CHANNELS; g++) begin : gen_sampler
			lineif_rx_sampler u_sampler (
				.core_clk(core_clk),
				.arst_n(arst_n),
				.rxClkPin(rxRecoveredClkIn[g]),
				.linePosPin(rx_line_positive_input[g]),
				.lineNegPin(rx_line_negative_input[g]),
				.clkLevel(clkLevel[g]),
				.clkRise(clkRise[g]),
				.linePos(linePos[g]),
				.lineNeg(lineNeg[g])
			);
		end
	endgenerate

	// Bus phases: read data are captured in setup, writes act in access.
	assign regHit = regSelect(paddr);
	assign setupRead = psel & ~penable & ~pwrite;
	assign accessWrite = psel & penable & pwrite & regHit[4];

	// Next state of decoders, loss detection, registers and read data.
	always_comb begin
		next_state = state;
		pulseNow = '0;
		violationNow = '0;
		stallNow = '0;
		lostNext = state.lost;
		muteNow = '0;
		next_state.muteMeta = rx_output_silence_on_loss;
		next_state.muteSync = state.muteMeta;
		for (int c = 0; c < CHANNELS; c++) begin
			pulseNow[c] = linePos[c] | lineNeg[c];
			// Both rails at once is always illegal; AMI also flags same polarity twice.
			violationNow[c] = (linePos[c] & lineNeg[c]) | (state.amiMode[c] & state.seenPulse[c]
				& ((linePos[c] & state.lastPositive[c]) | (lineNeg[c] & ~state.lastPositive[c])));
			// A recovered clock that stops for too long also counts as loss.
			stallNow[c] = (state.stallCount[c] == CLK_STALL_CYCLES);
			if (clkRise[c]) begin
				next_state.stallCount[c] = '0;
			end else if (!stallNow[c]) begin
				next_state.stallCount[c] = state.stallCount[c] + 7'h01;
			end
			if (stallNow[c]) begin
				lostNext[c] = 1'b1;
			end
			if (clkRise[c]) begin
				if (pulseNow[c]) begin
					next_state.zeroCount[c] = '0;
					next_state.seenPulse[c] = 1'b1;
					next_state.lastPositive[c] = linePos[c];
					lostNext[c] = 1'b0;
				end else begin
					if (state.zeroCount[c] != 8'hFF) begin
						next_state.zeroCount[c] = state.zeroCount[c] + 8'h01;
					end
					if (state.zeroCount[c] >= LOS_ZERO_LIMIT - 8'h01) begin
						lostNext[c] = 1'b1;
					end
				end
				muteNow[c] = state.muteSync & lostNext[c];
				next_state.clkOut[c] = clkLevel[c];
				if (state.singleRail[c]) begin
					next_state.posOut[c] = pulseNow[c] & ~muteNow[c];
					// The strobe is never muted, so every violation reaches the framer.
					next_state.negOut[c] = violationNow[c];
				end else begin
					next_state.posOut[c] = linePos[c] & ~muteNow[c];
					next_state.negOut[c] = lineNeg[c] & ~muteNow[c];
				end
			end else begin
				next_state.clkOut[c] = clkLevel[c];
				// A stalled clock mutes the data; the single-rail strobe is left alone.
				if (stallNow[c] && state.muteSync) begin
					next_state.posOut[c] = 1'b0;
					if (!state.singleRail[c]) begin
						next_state.negOut[c] = 1'b0;
					end
				end
			end
			next_state.lost[c] = lostNext[c];
		end
		// Software writes and write-one-to-clear; new events win over a clear.
		if (accessWrite && regHit[0]) begin
			next_state.singleRail = pwdata[CTRL_SINGLE_RAIL_LSB +: 4];
			next_state.amiMode = pwdata[CTRL_AMI_LSB +: 4];
		end
		if (accessWrite && regHit[3]) begin
			next_state.intMask = pwdata[7:0];
		end
		if (accessWrite && regHit[2]) begin
			next_state.intStatus = state.intStatus & ~pwdata[7:0];
		end
		next_state.intStatus[INT_LOSS_LSB +: 4] = next_state.intStatus[INT_LOSS_LSB +: 4]
			| (lostNext & ~state.lost);
		next_state.intStatus[INT_VIOLATION_LSB +: 4] = next_state.intStatus[INT_VIOLATION_LSB +: 4]
			| (violationNow & clkRise);
		// Read data are registered in the setup cycle for the access cycle.
		if (setupRead) begin
			case (regHit)
				5'h11: next_state.readData = {24'h00_0000, state.amiMode, state.singleRail};
				5'h12: next_state.readData = {27'h000_0000, state.muteSync, state.lost};
				5'h14: next_state.readData = {24'h00_0000, state.intStatus};
				5'h18: next_state.readData = {24'h00_0000, state.intMask};
				default: next_state.readData = 32'h0000_0000;
			endcase
		end
	end

	// State register with constant reset values.
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			state <= '0;
			state.singleRail <= CTRL_SINGLE_RAIL_RESET;
			state.amiMode <= CTRL_AMI_RESET;
			state.intMask <= INT_MASK_RESET;
		end else begin
			state <= next_state;
		end
	end

	// Bus answers at once in the access phase; unmapped addresses give an error.
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~regHit[4];
	assign prdata = state.readData;
	assign irq = |(state.intStatus & state.intMask);

	// Line side outputs, all from flip-flops.
	assign rxRecoveredClkOut = state.clkOut;
	assign rx_positive_rail_data = state.posOut;
	assign rx_negative_rail_data = state.negOut;
	assign rx_signal_lost_flag = state.lost;

	// Checks per channel on the core clock.
	// A stall tick is counted only when no link edge arrives in the same cycle,
	// because a mark on that edge ends the loss and wins over the stall.
	generate
		for (g = 0; g < CHANNELS; g++) begin : gen_check
			sequence s_zero_edge;
				clkRise[g] && !pulseNow[g];
			endsequence
			sequence s_mark_edge;
				clkRise[g] && pulseNow[g];
			endsequence
			// A stalled link clock declares loss without waiting for a link edge.
			sequence s_stall_tick;
				stallNow[g] && !clkRise[g];
			endsequence
			sequence s_violation_edge;
				clkRise[g] && violationNow[g];
			endsequence
			sequence s_quiet_edge;
				clkRise[g] && !violationNow[g];
			endsequence

			a_loss_raise_limit: assert property (@(posedge core_clk) disable iff (!arst_n)
				s_zero_edge and state.zeroCount[g] == LOS_ZERO_LIMIT - 8'h01 |=> rx_signal_lost_flag[g])
				else $error("loss flag not raised at zero limit");

			a_loss_held_high: assert property (@(posedge core_clk) disable iff (!arst_n)
				rx_signal_lost_flag[g] && !(clkRise[g] && pulseNow[g]) |=> rx_signal_lost_flag[g])
				else $error("loss flag dropped during loss");

			a_loss_release: assert property (@(posedge core_clk) disable iff (!arst_n)
				s_mark_edge |=> !rx_signal_lost_flag[g] && state.zeroCount[g] == 8'h00)
				else $error("loss flag not released on mark");

			a_dual_neg_rail: assert property (@(posedge core_clk) disable iff (!arst_n)
				clkRise[g] && !state.singleRail[g] && !muteNow[g]
				|=> rx_negative_rail_data[g] == $past(lineNeg[g]))
				else $error("negative rail differs from line");

			a_dual_pos_rail: assert property (@(posedge core_clk) disable iff (!arst_n)
				clkRise[g] && !state.singleRail[g] && !muteNow[g]
				|=> rx_positive_rail_data[g] == $past(linePos[g]))
				else $error("positive rail differs from line");

			a_nrz_data_out: assert property (@(posedge core_clk) disable iff (!arst_n)
				clkRise[g] && state.singleRail[g] && !muteNow[g]
				|=> rx_positive_rail_data[g] == ($past(linePos[g]) | $past(lineNeg[g])))
				else $error("nrz data wrong");

			a_strobe_one_clk: assert property (@(posedge core_clk) disable iff (!arst_n)
				rx_negative_rail_data[g] && state.singleRail[g] && !clkRise[g]
				|=> $stable(rx_negative_rail_data[g]))
				else $error("violation strobe changed off the clock edge");

			a_ami_bipolar_strobe: assert property (@(posedge core_clk) disable iff (!arst_n)
				clkRise[g] && state.singleRail[g] && state.amiMode[g] && state.seenPulse[g]
				&& linePos[g] && state.lastPositive[g] && !muteNow[g]
				|=> rx_negative_rail_data[g] ##1 state.intStatus[INT_VIOLATION_LSB + g])
				else $error("bipolar violation not flagged");

			a_mute_forces_low: assert property (@(posedge core_clk) disable iff (!arst_n)
				clkRise[g] && state.muteSync && lostNext[g]
				|=> !rx_positive_rail_data[g] && (state.singleRail[g] || !rx_negative_rail_data[g]))
				else $error("data not muted during loss");

			a_edge_aligned: assert property (@(posedge core_clk) disable iff (!arst_n)
				!clkRise[g] && !stallNow[g] |=> $stable(rx_positive_rail_data[g])
				&& $stable(rx_negative_rail_data[g]))
				else $error("data changed without clock edge");

			a_clock_out_follows: assert property (@(posedge core_clk) disable iff (!arst_n)
				clkRise[g] |=> rxRecoveredClkOut[g])
				else $error("recovered clock output missed edge");

			a_clock_out_low: assert property (@(posedge core_clk) disable iff (!arst_n)
				!clkLevel[g] |=> !rxRecoveredClkOut[g])
				else $error("recovered clock output missed fall");

			a_loss_no_edge: assert property (@(posedge core_clk) disable iff (!arst_n)
				!rx_signal_lost_flag[g] && !clkRise[g] && !stallNow[g]
				|=> !rx_signal_lost_flag[g])
				else $error("loss flag rose without cause");

			a_stall_loss: assert property (@(posedge core_clk) disable iff (!arst_n)
				s_stall_tick |=> rx_signal_lost_flag[g])
				else $error("loss flag not raised on stalled clock");

			a_loss_status: assert property (@(posedge core_clk) disable iff (!arst_n)
				!rx_signal_lost_flag[g] ##1 rx_signal_lost_flag[g] |-> state.intStatus[INT_LOSS_LSB + g])
				else $error("loss event not recorded");

			a_strobe_on_violation: assert property (@(posedge core_clk) disable iff (!arst_n)
				s_violation_edge and state.singleRail[g] |=> rx_negative_rail_data[g])
				else $error("violation strobe missing");

			a_strobe_quiet: assert property (@(posedge core_clk) disable iff (!arst_n)
				s_quiet_edge and state.singleRail[g] |=> !rx_negative_rail_data[g])
				else $error("violation strobe without violation");

			a_strobe_stall_kept: assert property (@(posedge core_clk) disable iff (!arst_n)
				s_stall_tick and state.singleRail[g]
				|=> $stable(rx_negative_rail_data[g]))
				else $error("violation strobe changed on stall");

			a_violation_status: assert property (@(posedge core_clk) disable iff (!arst_n)
				s_violation_edge |=> state.intStatus[INT_VIOLATION_LSB + g])
				else $error("violation event not recorded");

			a_stall_mute_pos: assert property (@(posedge core_clk) disable iff (!arst_n)
				s_stall_tick and state.muteSync |=> !rx_positive_rail_data[g])
				else $error("positive data not muted on stall");

			a_stall_mute_neg: assert property (@(posedge core_clk) disable iff (!arst_n)
				s_stall_tick and (state.muteSync && !state.singleRail[g])
				|=> !rx_negative_rail_data[g])
				else $error("negative data not muted on stall");
		end
	endgenerate

endmodule // lineif_receive_output_port

`default_nettype wire

// File: design/lineif_receive_output_port_pkg_note.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// File: design/lineif_rx_pkg.sv
package lineif_rx_pkg;

	// Number of receive channels served by the block.
	localparam int unsigned CHANNELS = 4;

	// Register byte offsets on the APB bus.
	localparam logic [11:0] OFFS_CONTROL = 12'h000;
	localparam logic [11:0] OFFS_LOSS_STATE = 12'h004;
	localparam logic [11:0] OFFS_INT_STATUS = 12'h008;
	localparam logic [11:0] OFFS_INT_MASK = 12'h00C;

	// Field positions inside the control register.
	localparam int unsigned CTRL_SINGLE_RAIL_LSB = 0;
	localparam int unsigned CTRL_AMI_LSB = 4;

	// Field positions inside the loss state register.
	localparam int unsigned LOSS_FLAG_LSB = 0;
	localparam int unsigned LOSS_MUTE_BIT = 4;

	// Field positions inside the interrupt status and mask registers.
	localparam int unsigned INT_LOSS_LSB = 0;
	localparam int unsigned INT_VIOLATION_LSB = 4;

	// Reset values of the writable registers.
	localparam logic [3:0] CTRL_SINGLE_RAIL_RESET = 4'h0;
	localparam logic [3:0] CTRL_AMI_RESET = 4'hF;
	localparam logic [7:0] INT_MASK_RESET = 8'h00;

	// Consecutive received zeros that declare loss of signal.
	localparam logic [7:0] LOS_ZERO_LIMIT = 8'h20;

	// Core clock rate and the least recovered clock silence that declares loss.
	localparam int unsigned CORE_CLK_MHZ = 50;
	localparam int unsigned CLK_STALL_NS = 2000;
	localparam logic [6:0] CLK_STALL_CYCLES = 7'((CLK_STALL_NS * CORE_CLK_MHZ + 999) / 1000);

endpackage

// File: design/lineif_rx_sampler.sv
`timescale 1ns/1ps
`default_nettype none

module lineif_rx_sampler (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic rxClkPin,
	input wire logic linePosPin,
	input wire logic lineNegPin,
	output logic clkLevel,
	output logic clkRise,
	output logic linePos,
	output logic lineNeg
);

	// Two synchroniser stages for clock, positive and negative line pulses.
	typedef struct packed {
		logic [2:0] meta;
		logic [2:0] sync;
		logic prevClk;
	} sampler_t;

	sampler_t state;
	sampler_t next_state;

	// The first stage feeds only the second; edge finding looks at the second.
	always_comb begin
		next_state = state;
		next_state.meta = {lineNegPin, linePosPin, rxClkPin};
		next_state.sync = state.meta;
		next_state.prevClk = state.sync[0];
	end

	// State register.
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	// Data pass the same path as the clock so they line up with its edge.
	assign clkLevel = state.sync[0];
	assign clkRise = state.sync[0] & ~state.prevClk;
	assign linePos = state.sync[1];
	assign lineNeg = state.sync[2];

endmodule // lineif_rx_sampler

`default_nettype wire

// File: testbench/lineif_framer_model.sv
`timescale 1ns/1ps
`default_nettype none

module lineif_framer_model (
	input wire logic [lineif_rx_pkg::CHANNELS-1:0] clkOut,
	input wire logic [lineif_rx_pkg::CHANNELS-1:0] railPos,
	input wire logic [lineif_rx_pkg::CHANNELS-1:0] railNeg,
	output var logic [lineif_rx_pkg::CHANNELS-1:0] seenPos,
	output var logic [lineif_rx_pkg::CHANNELS-1:0] seenNeg,
	output var int strobeCount [lineif_rx_pkg::CHANNELS]
);
	import lineif_rx_pkg::*;
	// The framer starts with nothing captured.
	initial begin
		seenPos = '0;
		seenNeg = '0;
		strobeCount = '{default: 0};
	end
	// Each channel is taken on the falling edge of its own clock, away from the update edge.
	for (genvar i = 0; i < CHANNELS; i++) begin : gChan
		always @(negedge clkOut[i]) begin
			seenPos[i] <= railPos[i];
			seenNeg[i] <= railNeg[i];
			if (railNeg[i] === 1'b1) begin
				strobeCount[i] <= strobeCount[i] + 1; // A high strobe counts once per clock.
			end
		end
	end
endmodule // lineif_framer_model
`default_nettype wire

// File: testbench/lineif_receive_output_port_tb.sv
`timescale 1ns/1ps
`default_nettype none

module lineif_receive_output_port_tb;
	import lineif_rx_pkg::*;
	logic core_clk, arst_n, psel, penable, pwrite, mute, e;
	logic [11:0] paddr;
	logic [31:0] pwdata, q;
	logic [3:0] clkIn, pos, neg;
	wire logic [31:0] prdata;
	wire logic pready, pslverr, irq;
	wire logic [3:0] clkOut, railPos, railNeg, lost, seenPos, seenNeg;
	int strobeCount [CHANNELS];
	int num_errors = 0;
	int n_tests = 0;
	int c0;

	lineif_receive_output_port DUT (.core_clk(core_clk), .arst_n(arst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .irq(irq), .rxRecoveredClkIn(clkIn),
		.rx_line_positive_input(pos), .rx_line_negative_input(neg),
		.rx_output_silence_on_loss(mute), .rxRecoveredClkOut(clkOut),
		.rx_positive_rail_data(railPos), .rx_negative_rail_data(railNeg),
		.rx_signal_lost_flag(lost));
	lineif_framer_model framer (.clkOut(clkOut), .railPos(railPos), .railNeg(railNeg),
		.seenPos(seenPos), .seenNeg(seenNeg), .strobeCount(strobeCount));

	// Prints the counts and the verdict, then stops the run.
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// Compares one value and reports a mismatch at once.
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask

	// One APB transfer; the request stands until pready is seen high.
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'b1 && n < 10);
		if (n >= 10) begin
			num_errors++;
			end_of_test();
		end
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge core_clk);
	endtask

	// One symbol on all four lines: levels change while the link clock is low.
	task automatic sym(input logic [3:0] p, input logic [3:0] n);
		clkIn <= 4'h0;
		pos <= p;
		neg <= n;
		repeat (4) @(posedge core_clk);
		clkIn <= 4'hF;
		repeat (4) @(posedge core_clk);
	endtask

	// Reset values and an unmapped address.
	task automatic t_reset();
		apb(1'b0, OFFS_CONTROL, 32'h0000_0000);
		check("control", q, 32'h0000_00F0);
		apb(1'b0, OFFS_INT_MASK, 32'h0000_0000);
		check("mask", q, 32'h0000_0000);
		apb(1'b0, 12'h010, 32'h0000_0000);
		check("unmapped", {q[30:0], e}, 32'h0000_0001);
		$display("test reset done");
	endtask

	// Dual rail: each channel carries its own pulses on both rails.
	task automatic t_dual();
		sym(4'h5, 4'hA);
		check("clock out", clkOut, 4'hF);
		check("pos rail", railPos, 4'h5);
		check("neg rail", railNeg, 4'hA);
		sym(4'hA, 4'h5);
		check("pos rail", railPos, 4'hA);
		check("framer pos", seenPos, 4'h5);
		check("framer neg", seenNeg, 4'hA);
		$display("test dual done");
	endtask

	// Single rail with AMI: NRZ data and violation strobes, then the interrupt.
	task automatic t_single();
		apb(1'b1, OFFS_CONTROL, 32'h0000_00FF);
		sym(4'hF, 4'h0);
		// The first fall still shows the dual-rail level, so counting starts after it.
		c0 = strobeCount[0];
		check("nrz", railPos, 4'hF);
		check("first strobe", railNeg, 4'hA);
		sym(4'h0, 4'hF);
		check("nrz", railPos, 4'hF);
		check("no strobe", railNeg, 4'h0);
		sym(4'h0, 4'hF);
		check("bipolar strobe", railNeg, 4'hF);
		sym(4'h0, 4'h0);
		check("strobe end", railNeg, 4'h0);
		sym(4'hF, 4'hF);
		check("both rails", railNeg, 4'hF);
		sym(4'h0, 4'h0);
		check("strobe count", strobeCount[0] - c0, 32'h0000_0002);
		apb(1'b0, OFFS_INT_STATUS, 32'h0000_0000);
		check("status", q[7:4], 4'hF);
		check("masked irq", irq, 1'b0);
		apb(1'b1, OFFS_INT_MASK, 32'h0000_00F0);
		check("irq", irq, 1'b1);
		apb(1'b1, OFFS_INT_STATUS, 32'h0000_00F0);
		check("cleared irq", irq, 1'b0);
		apb(1'b1, OFFS_CONTROL, 32'h0000_000F);
		sym(4'h0, 4'hF);
		sym(4'h0, 4'hF);
		check("ami off", railNeg, 4'h0);
		$display("test single done");
	endtask

	// Loss after exactly 32 zero symbols, held until the next mark.
	task automatic t_loss();
		sym(4'hF, 4'h0);
		check("no loss", lost, 4'h0);
		repeat (31) sym(4'h0, 4'h0);
		check("loss early", lost, 4'h0);
		sym(4'h0, 4'h0);
		check("loss set", lost, 4'hF);
		repeat (5) sym(4'h0, 4'h0);
		check("loss held", lost, 4'hF);
		sym(4'h0, 4'hF);
		check("loss end", lost, 4'h0);
		$display("test loss done");
	endtask

	// Muting: a stalled clock declares loss and the data outputs go low.
	task automatic t_mute();
		apb(1'b1, OFFS_CONTROL, 32'h0000_000F);
		mute <= 1'b1;
		sym(4'hF, 4'h0);
		check("unmuted data", railPos, 4'hF);
		repeat (120) @(posedge core_clk);
		check("stall loss", lost, 4'hF);
		check("muted data", railPos, 4'h0);
		apb(1'b0, OFFS_LOSS_STATE, 32'h0000_0000);
		check("loss state", q, 32'h0000_001F);
		apb(1'b0, OFFS_INT_STATUS, 32'h0000_0000);
		check("loss status", q[3:0], 4'hF);
		sym(4'h0, 4'h0);
		check("muted zero", railPos, 4'h0);
		check("loss kept", lost, 4'hF);
		sym(4'hF, 4'h0);
		check("loss gone", lost, 4'h0);
		check("data back", railPos, 4'hF);
		mute <= 1'b0;
		$display("test mute done");
	endtask

	// Core clock of 50 MHz.
	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end

	// Main sequence.
	initial begin
		arst_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		clkIn = '0;
		pos = '0;
		neg = '0;
		mute = 1'b0;
		repeat (16) @(posedge core_clk);
		arst_n <= 1'b1;
		@(posedge core_clk);
		t_reset();
		t_dual();
		t_single();
		t_loss();
		t_mute();
		end_of_test();
	end
endmodule // lineif_receive_output_port_tb
`default_nettype wire
